// ---- pabd_cfg.svh ----
`ifndef PABD_CFG_SVH
`define PABD_CFG_SVH
// width of the shared address/data lines
`define PABD_DW        32
// idle cycles with frame_n and trdy_n both high before a new address phase
`define PABD_QUIET_CYC 2
// data-phase cycles a master waits for trdy_n before giving up
`define PABD_ABORT_CYC 16
// target windows: an agent answers when (addr & mask) == (base & mask)
`define PABD_DEV_BASE  32'h0000_0000
`define PABD_HOST_BASE 32'h8000_0000
`define PABD_WIN_MASK  32'h8000_0000
// level seen on the address/data lines when nobody drives them
`define PABD_FLOAT     32'hffff_ffff
`endif

// ---- pabd_pkg.sv ----
`include "pabd_cfg.svh"
package pabd_pkg;
  typedef logic [`PABD_DW-1:0] pabd_word_t;

  // one agent's bus state, one-hot
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_M_ADDR = 7'h02,
    ST_M_DATA = 7'h04,
    ST_M_END  = 7'h08,
    ST_T_TURN = 7'h10,
    ST_T_DATA = 7'h20,
    ST_T_END  = 7'h40
  } pabd_state_t;

  // address window decode, shared by both ends
  function automatic logic pabd_hit(pabd_word_t a, pabd_word_t base, pabd_word_t mask);
    return (a & mask) == (base & mask);
  endfunction
endpackage

// ---- pabd_bus_if.sv ----
`timescale 1ns/1ps
`include "pabd_cfg.svh"
interface pabd_bus_if;
  import pabd_pkg::*;
  pabd_word_t dev_ad_o;
  pabd_word_t host_ad_o;
  pabd_word_t ad;
  logic       dev_ad_oe;
  logic       host_ad_oe;
  logic       dev_cmd_wr_o;
  logic       dev_cmd_wr_oe;
  logic       host_cmd_wr_o;
  logic       host_cmd_wr_oe;
  logic       cmd_wr;
  logic       dev_frame_n_o;
  logic       dev_frame_n_oe;
  logic       host_frame_n_o;
  logic       host_frame_n_oe;
  logic       frame_n;
  logic       dev_trdy_n_o;
  logic       dev_trdy_n_oe;
  logic       host_trdy_n_o;
  logic       host_trdy_n_oe;
  logic       trdy_n;
  logic       req_n;
  logic       gnt_n;

  // wire resolution; the pull-ups hold released ad, frame_n and trdy_n high, a released cmd_wr reads low
  assign ad      = dev_ad_oe ? dev_ad_o : (host_ad_oe ? host_ad_o : `PABD_FLOAT);
  assign cmd_wr  = dev_cmd_wr_oe ? dev_cmd_wr_o : (host_cmd_wr_oe & host_cmd_wr_o);
  assign frame_n = !(dev_frame_n_oe && !dev_frame_n_o) && !(host_frame_n_oe && !host_frame_n_o);
  assign trdy_n  = !(dev_trdy_n_oe && !dev_trdy_n_o) && !(host_trdy_n_oe && !host_trdy_n_o);

  modport dev (
    output dev_ad_o, dev_ad_oe, dev_cmd_wr_o, dev_cmd_wr_oe,
    output dev_frame_n_o, dev_frame_n_oe, dev_trdy_n_o, dev_trdy_n_oe, req_n,
    input  ad, cmd_wr, frame_n, trdy_n, gnt_n
  );
  modport host (
    output host_ad_o, host_ad_oe, host_cmd_wr_o, host_cmd_wr_oe,
    output host_frame_n_o, host_frame_n_oe, host_trdy_n_o, host_trdy_n_oe, gnt_n,
    input  ad, cmd_wr, frame_n, trdy_n, req_n
  );
endinterface

// ---- pabd_dev_end.sv ----
`timescale 1ns/1ps
`include "pabd_cfg.svh"
module pabd_dev_end #(
  parameter int                  QUIET_CYC = `PABD_QUIET_CYC,
  parameter int                  ABORT_CYC = `PABD_ABORT_CYC,
  parameter logic [`PABD_DW-1:0] OWN_BASE  = `PABD_DEV_BASE,
  parameter logic [`PABD_DW-1:0] WIN_MASK  = `PABD_WIN_MASK
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  pabd_bus_if.dev                   bus,
  input  wire logic                 mst_req,
  input  wire logic                 mst_wr,
  input  wire pabd_pkg::pabd_word_t mst_addr,
  input  wire pabd_pkg::pabd_word_t mst_wdata,
  output logic                      mst_done,
  output logic                      mst_abort,
  output pabd_pkg::pabd_word_t      mst_rdata,
  output pabd_pkg::pabd_word_t      tgt_addr,
  output pabd_pkg::pabd_word_t      tgt_wdata,
  output logic                      tgt_wr,
  output logic                      tgt_rd,
  input  wire pabd_pkg::pabd_word_t tgt_rdata
);
  import pabd_pkg::*;

  localparam logic [7:0] QUIET8 = 8'(QUIET_CYC);
  localparam logic [7:0] LAST8  = 8'(ABORT_CYC - 1);

  // counters are 8 bits wide; fewer than two quiet cycles can overlap owners
  if (QUIET_CYC < 2 || QUIET_CYC > 255 || ABORT_CYC < 1 || ABORT_CYC > 256) begin : g_chk
    $error("pabd_dev_end: QUIET_CYC or ABORT_CYC out of range");
  end

  pabd_state_t st_reg, st_next;
  pabd_word_t  ad_o_reg, ad_o_next;
  pabd_word_t  rdata_reg, rdata_next;
  pabd_word_t  taddr_reg, taddr_next;
  pabd_word_t  twdata_reg, twdata_next;
  logic        ad_oe_reg, ad_oe_next;
  logic        frm_o_reg, frm_o_next;
  logic        frm_oe_reg, frm_oe_next;
  logic        trdy_o_reg, trdy_o_next;
  logic        trdy_oe_reg, trdy_oe_next;
  logic        cmd_o_reg, cmd_o_next;
  logic        cmd_oe_reg, cmd_oe_next;
  logic        wr_reg, wr_next;
  logic        done_reg, done_next;
  logic        abort_reg, abort_next;
  logic        twr_reg, twr_next;
  logic        trd_reg, trd_next;
  logic [7:0]  wait_reg, wait_next;
  logic [7:0]  quiet_reg, quiet_next;
  logic        frm_prev_reg, frm_prev_next;
  logic        mst_go, tgt_hit;

  //////////////////////////////////////////////////////////////////////////
  // bus watch: frame start and idle-gap counting

  // every owner drives high before releasing, so two high cycles mean all gone
  always_comb begin
    frm_prev_next = bus.frame_n;
    if (!bus.frame_n || !bus.trdy_n) begin
      quiet_next = 8'h00;
    end else if (quiet_reg != QUIET8) begin
      quiet_next = quiet_reg + 8'h01;
    end else begin
      quiet_next = quiet_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frm_prev_reg <= 1'b1;
      quiet_reg    <= 8'h00;
    end else begin
      frm_prev_reg <= frm_prev_next;
      quiet_reg    <= quiet_next;
    end
  end

  // start only when granted and the lines have been handed back
  assign mst_go  = (st_reg == ST_IDLE) && mst_req && !bus.gnt_n
                   && (quiet_reg == QUIET8);
  assign tgt_hit = (st_reg == ST_IDLE) && !bus.frame_n && frm_prev_reg
                   && pabd_hit(bus.ad, OWN_BASE, WIN_MASK);

  //////////////////////////////////////////////////////////////////////////
  // transaction state machine, master and target roles

  always_comb begin
    st_next      = st_reg;
    ad_o_next    = ad_o_reg;
    ad_oe_next   = ad_oe_reg;
    frm_o_next   = frm_o_reg;
    frm_oe_next  = frm_oe_reg;
    trdy_o_next  = trdy_o_reg;
    trdy_oe_next = trdy_oe_reg;
    cmd_o_next   = cmd_o_reg;
    cmd_oe_next  = cmd_oe_reg;
    wr_next      = wr_reg;
    wait_next    = wait_reg;
    rdata_next   = rdata_reg;
    taddr_next   = taddr_reg;
    twdata_next  = twdata_reg;
    done_next    = 1'b0;
    abort_next   = 1'b0;
    twr_next     = 1'b0;
    trd_next     = 1'b0;
    unique case (st_reg)
      ST_IDLE: begin
        if (mst_go) begin
          st_next     = ST_M_ADDR;
          ad_o_next   = mst_addr;
          ad_oe_next  = 1'b1;
          frm_o_next  = 1'b0;
          frm_oe_next = 1'b1;
          cmd_o_next  = mst_wr;
          cmd_oe_next = 1'b1;
          wr_next     = mst_wr;
        end else if (tgt_hit) begin
          taddr_next = bus.ad;
          wr_next    = bus.cmd_wr;
          if (bus.cmd_wr) begin
            st_next      = ST_T_DATA;
            trdy_o_next  = 1'b0;
            trdy_oe_next = 1'b1;
          end else begin
            st_next  = ST_T_TURN;
            trd_next = 1'b1;
          end
        end
      end
      ST_M_ADDR: begin
        st_next     = ST_M_DATA;
        cmd_oe_next = 1'b0;
        wait_next   = 8'h00;
        ad_o_next   = mst_wdata;
        ad_oe_next  = wr_reg;
      end
      ST_M_DATA: begin
        wait_next = wait_reg + 8'h01;
        // no target after the wait limit ends the cycle as an abort
        if (!bus.trdy_n || wait_reg == LAST8) begin
          st_next    = ST_M_END;
          frm_o_next = 1'b1;
          ad_oe_next = 1'b0;
          done_next  = !bus.trdy_n;
          abort_next = bus.trdy_n;
          if (!wr_reg && !bus.trdy_n) begin
            rdata_next = bus.ad;
          end
        end
      end
      ST_M_END: begin
        st_next     = ST_IDLE;
        frm_oe_next = 1'b0;
      end
      ST_T_TURN: begin
        // the master let go of ad at the edge that began this cycle; frame_n stays with it
        st_next      = ST_T_DATA;
        ad_o_next    = tgt_rdata;
        ad_oe_next   = 1'b1;
        trdy_o_next  = 1'b0;
        trdy_oe_next = 1'b1;
      end
      ST_T_DATA: begin
        st_next     = ST_T_END;
        trdy_o_next = 1'b1;
        ad_oe_next  = 1'b0;
        if (wr_reg) begin
          twdata_next = bus.ad;
          twr_next    = 1'b1;
        end
      end
      ST_T_END: begin
        st_next      = ST_IDLE;
        trdy_oe_next = 1'b0;
      end
      default: begin
        // illegal code: let go of everything
        st_next      = ST_IDLE;
        ad_oe_next   = 1'b0;
        frm_oe_next  = 1'b0;
        trdy_oe_next = 1'b0;
        cmd_oe_next  = 1'b0;
      end
    endcase
  end

  // pins other than req_n change on the rising edge or at reset only; req_n follows mst_req directly in ST_IDLE and stays high in other states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg      <= ST_IDLE;
      ad_o_reg    <= '0;
      ad_oe_reg   <= 1'b0;
      frm_o_reg   <= 1'b1;
      frm_oe_reg  <= 1'b0;
      trdy_o_reg  <= 1'b1;
      trdy_oe_reg <= 1'b0;
      cmd_o_reg   <= 1'b0;
      cmd_oe_reg  <= 1'b0;
      wr_reg      <= 1'b0;
      wait_reg    <= 8'h00;
      rdata_reg   <= '0;
      taddr_reg   <= '0;
      twdata_reg  <= '0;
      done_reg    <= 1'b0;
      abort_reg   <= 1'b0;
      twr_reg     <= 1'b0;
      trd_reg     <= 1'b0;
    end else begin
      st_reg      <= st_next;
      ad_o_reg    <= ad_o_next;
      ad_oe_reg   <= ad_oe_next;
      frm_o_reg   <= frm_o_next;
      frm_oe_reg  <= frm_oe_next;
      trdy_o_reg  <= trdy_o_next;
      trdy_oe_reg <= trdy_oe_next;
      cmd_o_reg   <= cmd_o_next;
      cmd_oe_reg  <= cmd_oe_next;
      wr_reg      <= wr_next;
      wait_reg    <= wait_next;
      rdata_reg   <= rdata_next;
      taddr_reg   <= taddr_next;
      twdata_reg  <= twdata_next;
      done_reg    <= done_next;
      abort_reg   <= abort_next;
      twr_reg     <= twr_next;
      trd_reg     <= trd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pins and user side

  assign bus.dev_ad_o       = ad_o_reg;
  assign bus.dev_ad_oe      = ad_oe_reg;
  assign bus.dev_frame_n_o  = frm_o_reg;
  assign bus.dev_frame_n_oe = frm_oe_reg;
  assign bus.dev_trdy_n_o   = trdy_o_reg;
  assign bus.dev_trdy_n_oe  = trdy_oe_reg;
  assign bus.dev_cmd_wr_o   = cmd_o_reg;
  assign bus.dev_cmd_wr_oe  = cmd_oe_reg;
  assign bus.req_n          = !(mst_req && st_reg == ST_IDLE);
  assign mst_done           = done_reg;
  assign mst_abort          = abort_reg;
  assign mst_rdata          = rdata_reg;
  assign tgt_addr           = taddr_reg;
  assign tgt_wdata          = twdata_reg;
  assign tgt_wr             = twr_reg;
  assign tgt_rd             = trd_reg;   // tgt_rdata is taken in this same cycle
endmodule

// ---- pabd_host_end.sv ----
`timescale 1ns/1ps
`include "pabd_cfg.svh"
module pabd_host_end #(
  parameter int                  QUIET_CYC = `PABD_QUIET_CYC,
  parameter int                  ABORT_CYC = `PABD_ABORT_CYC,
  parameter logic [`PABD_DW-1:0] OWN_BASE  = `PABD_HOST_BASE,
  parameter logic [`PABD_DW-1:0] WIN_MASK  = `PABD_WIN_MASK
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  pabd_bus_if.host                  bus,
  input  wire logic                 mst_req,
  input  wire logic                 mst_wr,
  input  wire pabd_pkg::pabd_word_t mst_addr,
  input  wire pabd_pkg::pabd_word_t mst_wdata,
  output logic                      mst_done,
  output logic                      mst_abort,
  output pabd_pkg::pabd_word_t      mst_rdata,
  output pabd_pkg::pabd_word_t      tgt_addr,
  output pabd_pkg::pabd_word_t      tgt_wdata,
  output logic                      tgt_wr,
  output logic                      tgt_rd,
  input  wire pabd_pkg::pabd_word_t tgt_rdata
);
  import pabd_pkg::*;

  localparam logic [7:0] QUIET8 = 8'(QUIET_CYC);
  localparam logic [7:0] LAST8  = 8'(ABORT_CYC - 1);

  if (QUIET_CYC < 2 || QUIET_CYC > 255 || ABORT_CYC < 1 || ABORT_CYC > 256) begin : g_chk
    $error("pabd_host_end: QUIET_CYC or ABORT_CYC out of range");
  end

  pabd_state_t st_reg, st_next;
  pabd_word_t  ad_o_reg, ad_o_next, rdata_reg, rdata_next;
  pabd_word_t  taddr_reg, taddr_next, twdata_reg, twdata_next;
  logic        ad_oe_reg, ad_oe_next, frm_o_reg, frm_o_next, frm_oe_reg, frm_oe_next;
  logic        trdy_o_reg, trdy_o_next, trdy_oe_reg, trdy_oe_next;
  logic        cmd_o_reg, cmd_o_next, cmd_oe_reg, cmd_oe_next, wr_reg, wr_next;
  logic        done_reg, done_next, abort_reg, abort_next;
  logic        twr_reg, twr_next, trd_reg, trd_next, gnt_n_reg, gnt_n_next;
  logic [7:0]  wait_reg, wait_next, quiet_reg, quiet_next;
  logic        frm_prev_reg, frm_prev_next, mst_go, tgt_hit;

  //////////////////////////////////////////////////////////////////////////
  // bus watch and grant; once quiet_reg is at QUIET8 the host wins a tie and the device may wait behind it, before that the device wins

  always_comb begin
    frm_prev_next = bus.frame_n;
    gnt_n_next    = !(!bus.req_n && st_reg == ST_IDLE && !mst_go);
    if (!bus.frame_n || !bus.trdy_n) begin
      quiet_next = 8'h00;
    end else if (quiet_reg != QUIET8) begin
      quiet_next = quiet_reg + 8'h01;
    end else begin
      quiet_next = quiet_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frm_prev_reg <= 1'b1;
      quiet_reg    <= 8'h00;
      gnt_n_reg    <= 1'b1;
    end else begin
      frm_prev_reg <= frm_prev_next;
      quiet_reg    <= quiet_next;
      gnt_n_reg    <= gnt_n_next;
    end
  end

  // grant low in this cycle (gnt_n_reg, set at the last edge) keeps the host from starting now
  assign mst_go  = (st_reg == ST_IDLE) && mst_req && gnt_n_reg
                   && (quiet_reg == QUIET8);
  assign tgt_hit = (st_reg == ST_IDLE) && !bus.frame_n && frm_prev_reg
                   && pabd_hit(bus.ad, OWN_BASE, WIN_MASK);

  //////////////////////////////////////////////////////////////////////////
  // transaction state machine

  always_comb begin
    st_next      = st_reg;
    ad_o_next    = ad_o_reg;
    ad_oe_next   = ad_oe_reg;
    frm_o_next   = frm_o_reg;
    frm_oe_next  = frm_oe_reg;
    trdy_o_next  = trdy_o_reg;
    trdy_oe_next = trdy_oe_reg;
    cmd_o_next   = cmd_o_reg;
    cmd_oe_next  = cmd_oe_reg;
    wr_next      = wr_reg;
    wait_next    = wait_reg;
    rdata_next   = rdata_reg;
    taddr_next   = taddr_reg;
    twdata_next  = twdata_reg;
    done_next    = 1'b0;
    abort_next   = 1'b0;
    twr_next     = 1'b0;
    trd_next     = 1'b0;
    unique case (st_reg)
      ST_IDLE: begin
        if (mst_go) begin
          st_next     = ST_M_ADDR;
          ad_o_next   = mst_addr;
          ad_oe_next  = 1'b1;
          frm_o_next  = 1'b0;
          frm_oe_next = 1'b1;
          cmd_o_next  = mst_wr;
          cmd_oe_next = 1'b1;
          wr_next     = mst_wr;
        end else if (tgt_hit) begin
          taddr_next = bus.ad;
          wr_next    = bus.cmd_wr;
          st_next    = bus.cmd_wr ? ST_T_DATA : ST_T_TURN;
          trd_next   = !bus.cmd_wr;
          if (bus.cmd_wr) begin
            trdy_o_next  = 1'b0;
            trdy_oe_next = 1'b1;
          end
        end
      end
      ST_M_ADDR: begin
        st_next     = ST_M_DATA;
        cmd_oe_next = 1'b0;
        wait_next   = 8'h00;
        ad_o_next   = mst_wdata;
        ad_oe_next  = wr_reg;
      end
      ST_M_DATA: begin
        wait_next = wait_reg + 8'h01;
        if (!bus.trdy_n || wait_reg == LAST8) begin
          st_next    = ST_M_END;
          frm_o_next = 1'b1;
          ad_oe_next = 1'b0;
          done_next  = !bus.trdy_n;
          abort_next = bus.trdy_n;
          if (!wr_reg && !bus.trdy_n) begin
            rdata_next = bus.ad;
          end
        end
      end
      ST_M_END: begin
        st_next     = ST_IDLE;
        frm_oe_next = 1'b0;
      end
      ST_T_TURN: begin
        st_next      = ST_T_DATA;
        ad_o_next    = tgt_rdata;
        ad_oe_next   = 1'b1;
        trdy_o_next  = 1'b0;
        trdy_oe_next = 1'b1;
      end
      ST_T_DATA: begin
        st_next     = ST_T_END;
        trdy_o_next = 1'b1;
        ad_oe_next  = 1'b0;
        if (wr_reg) begin
          twdata_next = bus.ad;
          twr_next    = 1'b1;
        end
      end
      ST_T_END: begin
        st_next      = ST_IDLE;
        trdy_oe_next = 1'b0;
      end
      default: begin
        st_next      = ST_IDLE;
        ad_oe_next   = 1'b0;
        frm_oe_next  = 1'b0;
        trdy_oe_next = 1'b0;
        cmd_oe_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg      <= ST_IDLE;
      ad_o_reg    <= '0;
      ad_oe_reg   <= 1'b0;
      frm_o_reg   <= 1'b1;
      frm_oe_reg  <= 1'b0;
      trdy_o_reg  <= 1'b1;
      trdy_oe_reg <= 1'b0;
      cmd_o_reg   <= 1'b0;
      cmd_oe_reg  <= 1'b0;
      wr_reg      <= 1'b0;
      wait_reg    <= 8'h00;
      rdata_reg   <= '0;
      taddr_reg   <= '0;
      twdata_reg  <= '0;
      done_reg    <= 1'b0;
      abort_reg   <= 1'b0;
      twr_reg     <= 1'b0;
      trd_reg     <= 1'b0;
    end else begin
      st_reg      <= st_next;
      ad_o_reg    <= ad_o_next;
      ad_oe_reg   <= ad_oe_next;
      frm_o_reg   <= frm_o_next;
      frm_oe_reg  <= frm_oe_next;
      trdy_o_reg  <= trdy_o_next;
      trdy_oe_reg <= trdy_oe_next;
      cmd_o_reg   <= cmd_o_next;
      cmd_oe_reg  <= cmd_oe_next;
      wr_reg      <= wr_next;
      wait_reg    <= wait_next;
      rdata_reg   <= rdata_next;
      taddr_reg   <= taddr_next;
      twdata_reg  <= twdata_next;
      done_reg    <= done_next;
      abort_reg   <= abort_next;
      twr_reg     <= twr_next;
      trd_reg     <= trd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pins and user side

  assign bus.host_ad_o       = ad_o_reg;
  assign bus.host_ad_oe      = ad_oe_reg;
  assign bus.host_frame_n_o  = frm_o_reg;
  assign bus.host_frame_n_oe = frm_oe_reg;
  assign bus.host_trdy_n_o   = trdy_o_reg;
  assign bus.host_trdy_n_oe  = trdy_oe_reg;
  assign bus.host_cmd_wr_o   = cmd_o_reg;
  assign bus.host_cmd_wr_oe  = cmd_oe_reg;
  assign bus.gnt_n           = gnt_n_reg;
  assign mst_done            = done_reg;
  assign mst_abort           = abort_reg;
  assign mst_rdata           = rdata_reg;
  assign tgt_addr            = taddr_reg;
  assign tgt_wdata           = twdata_reg;
  assign tgt_wr              = twr_reg;
  assign tgt_rd              = trd_reg;
endmodule

// ---- pabd_assertions.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// watch on the shared wires between the two ends; plain inputs, no bind
module pabd_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dev_ad_oe,
  input wire logic host_ad_oe,
  input wire logic dev_frame_n_o,
  input wire logic dev_frame_n_oe,
  input wire logic host_frame_n_oe,
  input wire logic host_trdy_n_o,
  input wire logic host_trdy_n_oe,
  input wire logic frame_n,
  input wire logic trdy_n,
  input wire logic cmd_wr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // ownership of the sustained and tri-state lines
  ad_one_owner_a: assert property (!(dev_ad_oe && host_ad_oe))
    else $error("both ends drive ad");
  frame_one_owner_a: assert property (!(dev_frame_n_oe && host_frame_n_oe))
    else $error("both ends drive frame_n");
  frame_park_high_a: assert property ($fell(dev_frame_n_oe) |-> $past(dev_frame_n_o))
    else $error("frame_n released without a high cycle");
  trdy_park_high_a: assert property ($fell(host_trdy_n_oe) |-> $past(host_trdy_n_o))
    else $error("trdy_n released without a high cycle");
  frame_takeover_a: assert property ($rose(host_frame_n_oe) |-> !$past(dev_frame_n_oe))
    else $error("frame_n taken over too early");

  ////////////////////////////////////////////////////////////////////////////////
  // direction of ad per phase
  addr_phase_dir_a: assert property ($fell(frame_n) |-> (dev_ad_oe == dev_frame_n_oe) &&
    (host_ad_oe == host_frame_n_oe) && (dev_ad_oe || host_ad_oe))
    else $error("address phase not driven by master alone");
  read_release_a: assert property ($fell(frame_n) && !cmd_wr && dev_frame_n_oe |=> !dev_ad_oe)
    else $error("master kept ad on a read");
  write_keep_a: assert property ($fell(frame_n) && cmd_wr && dev_frame_n_oe |=> dev_ad_oe)
    else $error("master released ad on a write");
  data_driven_a: assert property (!trdy_n |-> dev_ad_oe != host_ad_oe)
    else $error("ad not driven by one end in the data cycle");
  trdy_single_a: assert property ($fell(trdy_n) |=> trdy_n)
    else $error("more than one data cycle");
  idle_float_a: assert property (frame_n && trdy_n && !dev_frame_n_oe && !host_frame_n_oe
    |-> !dev_ad_oe && !host_ad_oe)
    else $error("ad driven on an idle bus");

  // main traffic kinds
  cover property ($fell(frame_n) && cmd_wr && dev_frame_n_oe);
  cover property ($fell(frame_n) && !cmd_wr && host_frame_n_oe);
  cover property ($fell(trdy_n));
endmodule

// ---- test_pci_ad_bus_direction_control.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_pci_ad_bus_direction_control;
  import pabd_pkg::*;
  typedef struct packed {logic ab; logic wr; pabd_word_t addr; pabd_word_t data;} pabd_note_t;
  logic       clk = 0;
  logic       rst_n = 0;
  logic       pf = 1;
  logic       m_req[2], m_wr[2], m_done[2], m_abort[2], t_wr[2], t_rd[2];
  pabd_word_t m_addr[2], m_wdata[2], m_rdata[2], t_addr[2], t_wdata[2], t_rdata[2];
  pabd_note_t q[2][$];
  int         num_errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  pabd_word_t ad_mid = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // two ends facing each other; bits 31:30 = 1x is claimed by nobody
  pabd_bus_if pabd_bus_if_i ();
  pabd_dev_end #(.ABORT_CYC(4), .WIN_MASK(32'hc000_0000)) pabd_dev_end_i (
    .clk(clk), .rst_n(rst_n), .bus(pabd_bus_if_i.dev), .mst_req(m_req[0]), .mst_wr(m_wr[0]),
    .mst_addr(m_addr[0]), .mst_wdata(m_wdata[0]), .mst_done(m_done[0]), .mst_abort(m_abort[0]),
    .mst_rdata(m_rdata[0]), .tgt_addr(t_addr[0]), .tgt_wdata(t_wdata[0]), .tgt_wr(t_wr[0]),
    .tgt_rd(t_rd[0]), .tgt_rdata(t_rdata[0]));
  pabd_host_end #(.ABORT_CYC(4), .OWN_BASE(32'h4000_0000), .WIN_MASK(32'hc000_0000)) pabd_host_end_i (
    .clk(clk), .rst_n(rst_n), .bus(pabd_bus_if_i.host), .mst_req(m_req[1]), .mst_wr(m_wr[1]),
    .mst_addr(m_addr[1]), .mst_wdata(m_wdata[1]), .mst_done(m_done[1]), .mst_abort(m_abort[1]),
    .mst_rdata(m_rdata[1]), .tgt_addr(t_addr[1]), .tgt_wdata(t_wdata[1]), .tgt_wr(t_wr[1]),
    .tgt_rd(t_rd[1]), .tgt_rdata(t_rdata[1]));
  pabd_assertions pabd_assertions_i (.clk(clk), .rst_n(rst_n),
    .dev_ad_oe(pabd_bus_if_i.dev_ad_oe), .host_ad_oe(pabd_bus_if_i.host_ad_oe),
    .dev_frame_n_o(pabd_bus_if_i.dev_frame_n_o), .dev_frame_n_oe(pabd_bus_if_i.dev_frame_n_oe),
    .host_frame_n_oe(pabd_bus_if_i.host_frame_n_oe), .host_trdy_n_o(pabd_bus_if_i.host_trdy_n_o),
    .host_trdy_n_oe(pabd_bus_if_i.host_trdy_n_oe), .frame_n(pabd_bus_if_i.frame_n),
    .trdy_n(pabd_bus_if_i.trdy_n), .cmd_wr(pabd_bus_if_i.cmd_wr));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; 42 short transfers need far fewer cycles
  initial forever #2 clk = ~clk;
  // ad seen just after each rising edge must still stand at the falling edge
  always @(posedge clk) begin
    #1;
    ad_mid = pabd_bus_if_i.ad;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one transfer from end m; the note is queued before the request goes out
  task automatic xfer(input int m, input logic wr, input logic [1:0] top);
    pabd_note_t n;
    int k;
    n = '{top[1], wr, {top, 30'($urandom)}, 32'($urandom)};
    q[m].push_back(n);
    m_wr[m] = wr;
    m_addr[m] = n.addr;
    m_wdata[m] = wr ? n.data : 32'($urandom);
    t_rdata[1-m] = n.data;
    m_req[m] = 1'b1;
    k = 0;
    while (!(m_done[m] || m_abort[m]) && k < 100) begin
      @(negedge clk);
      k++;
    end
    `CHK("xfer_end", 1'b1, k < 100)
    m_req[m] = 1'b0; // drop before the next edge, else a new transfer starts
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watcher: wire level on every cycle, then the oldest note on each completion
  always @(negedge clk) begin : watch
    pabd_note_t n;
    int mi;
    mi = pabd_bus_if_i.host_frame_n_oe;
    pf <= pabd_bus_if_i.frame_n;
    if (!pabd_bus_if_i.dev_ad_oe && !pabd_bus_if_i.host_ad_oe)
      `CHK("float", 32'hffff_ffff, pabd_bus_if_i.ad)
    `CHK("ad_mid", ad_mid, pabd_bus_if_i.ad)
    if (rst_n && pf && !pabd_bus_if_i.frame_n && q[mi].size() > 0) begin
      `CHK("ad_addr", q[mi][0].addr, pabd_bus_if_i.ad)
      `CHK("cmd_wr", q[mi][0].wr, pabd_bus_if_i.cmd_wr)
    end
    for (int m = 0; m < 2; m++) begin
      if (t_rd[1-m])
        `CHK("tgt_rd", 2'b10, {q[m].size() > 0, q[m][0].wr})
      if (m_done[m] || m_abort[m]) begin
        n = q[m].size() > 0 ? q[m].pop_front() : '1;
        `CHK("abort", n.ab, m_abort[m])
        if (!n.ab) begin
          `CHK("tgt_addr", n.addr, t_addr[1-m])
          `CHK("tgt_wr", n.wr, t_wr[1-m])
          if (n.wr) `CHK("wdata", n.data, t_wdata[1-m])
          else `CHK("rdata", n.data, m_rdata[m])
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: random traffic, ties, reset in mid-run
  initial begin
    void'($urandom(25119));
    foreach (m_req[i]) begin
      m_req[i] = 0; m_wr[i] = 0; m_addr[i] = '0; m_wdata[i] = '0; t_rdata[i] = '0;
    end
    repeat (12) @(negedge clk);
    rst_n = 1;
    repeat (30) begin
      int m;
      m = $urandom % 2;
      xfer(m, 1'($urandom), ($urandom % 3 == 0) ? {1'b1, 1'($urandom)} : (m ? 2'b00 : 2'b01));
    end
    // both ends ask together; ownership must pass cleanly
    repeat (4) fork
      xfer(0, 1'($urandom), 2'b01);
      xfer(1, 1'($urandom), 2'b00);
    join
    rst_n = 0;
    @(negedge clk);
    `CHK("oe_reset", 3'h0, {pabd_bus_if_i.dev_ad_oe, pabd_bus_if_i.host_ad_oe,
      pabd_bus_if_i.dev_frame_n_oe})
    repeat (2) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < 4; i++) xfer(i % 2, i[1], i % 2 ? 2'b00 : 2'b01);
    `CHK("notes_left", 0, q[0].size() + q[1].size())
    conclude();
  end
endmodule
